//--- src/reset_supervisor_watchdog.sv
// Reset supervisor: power-fail hold, pushbutton debounce and watchdog,
// driving a shared active-low reset line.
// Assumes an external pull-up on the reset line and a 40 MHz sys_clk.
//
// Summary of operation
// R1: Power-fail indication forces reset active.
// R2: Hold reset 250 ms after power recovers.
// R3: Oscillator disabled adds startup time to hold.
// R4: Watch reset line for falling edge when idle.
// R5: On edge, pull low, start 250 ms debounce.
// R6: After debounce, wait for line release if low.
// R7: On release, hold line low 250 ms.
// R8: Period select: 01=250, 10=500, 11=1000 ms.
// R9: Period select 00 disables the watchdog.
// R10: Watchdog counts only while reset is inactive.
// R11: Power-up selects 1000 ms, watchdog enabled.
// R12: Strobe falling edge restarts full period.
// R13: Watchdog expiry drives reset for 250 ms.
// R14: Processor strobes within minimum selected period.
// R15: Period select in bits 1..0, others zero.
// R16: Fixed-zero bits always read as zero.
// R17: Write-lock set ignores register writes.
// R18: All intervals count a millisecond tick.
// R19: Reset line only pulled low, never high.
`timescale 1ns/10ps

module reset_supervisor_watchdog #(
  parameter int unsigned TICK_CYC = supervisor_pkg::TICK_CYCLES,  // Cycles per ms tick
  parameter logic [11:0] OSC_START_MS = 12'h00a  // Oscillator startup allowance, arbitrary
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,                        // Freezes all state when low
  input wire logic powerFail,                    // Supply monitor, high = below trip
  input wire logic osc_disable,                  // Oscillator-disable control bit
  input wire logic wrLock,                       // Write-lock control bit
  input wire logic wd_strobe_in,                 // Watchdog strobe pin
  input wire logic rstLineIn,                    // Level seen on reset line
  input wire supervisor_pkg::reg_write_type regWr, // Watchdog register write
  output logic [7:0] regRdData,                  // Watchdog register readback
  output logic rstLineOut,                       // Reset line drive level
  output logic rstLineOe_n,                      // Low while pulling line low
  output logic resetActive                       // Supervisor holds reset
);
  import supervisor_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned NSYNC = 3;             // Asynchronous inputs
  localparam int unsigned IDX_PF = 0;
  localparam int unsigned IDX_ST = 1;
  localparam int unsigned IDX_LN = 2;
  // Strobe and line idle high; supply assumed failed until seen good
  localparam logic [NSYNC-1:0] SYNC_RST = 3'h7;

  logic [NSYNC-1:0] rawIn;                        // Pin levels
  logic [NSYNC-1:0] filt_reg;                     // Accepted levels
  logic [NSYNC-1:0] filtPrev_reg;                 // Previous accepted levels
  assign rawIn = {rstLineIn, wd_strobe_in, powerFail};

  // Three stages; a change counts once stages two and three agree
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        // All stages start at the SYNC_RST level, idle for strobe and line, so no false edge follows reset
        s1_reg <= SYNC_RST[i];
        s2_reg <= SYNC_RST[i];
        s3_reg <= SYNC_RST[i];
        filt_reg[i] <= SYNC_RST[i];
        filtPrev_reg[i] <= SYNC_RST[i];
      end else if (clkEn) begin
        s1_reg <= rawIn[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) begin
          filt_reg[i] <= s3_reg;
        end
        filtPrev_reg[i] <= filt_reg[i];
      end
    end
  end

  // Named conditions on the filtered inputs
  wire pfActive = filt_reg[IDX_PF];
  wire strobeFall = filtPrev_reg[IDX_ST] & ~filt_reg[IDX_ST];  // [R12]
  wire lineFall = filtPrev_reg[IDX_LN] & ~filt_reg[IDX_LN];    // [R4]
  wire lineHigh = filt_reg[IDX_LN];

  // ----------------------------------------------------------------
  // Millisecond timebase
  // ----------------------------------------------------------------
  localparam int unsigned PRE_W = $clog2(TICK_CYC);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);

  logic [PRE_W-1:0] pre_reg;                      // Prescaler
  wire msTick = (pre_reg == PRE_LAST);            // One tick per ms [R18]

  // Free running; intervals may start up to one tick short
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= '0;
    end else if (clkEn) begin
      pre_reg <= msTick ? '0 : pre_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog register
  // ----------------------------------------------------------------
  logic [1:0] psel_reg;                           // Period select field
  wire wrAccept = regWr.en & ~wrLock;             // Locked writes dropped [R17]
  wire [1:0] wrSel = {regWr.data[PSEL_HI_BIT], regWr.data[PSEL_LO_BIT]};  // [R15]
  // Select as it stands after this edge, so a write reloads with its own period
  wire [1:0] pselEff = wrAccept ? wrSel : psel_reg;

  // Power-up value enables the longest period
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      psel_reg <= PSEL_RESET;                     // [R11]
      regRdData <= '0;
    end else if (clkEn) begin
      if (wrAccept) begin
        psel_reg <= wrSel;                        // [R15]
      end
      regRdData <= {FIXED_ZERO, psel_reg};        // Upper bits forced zero [R16]
    end
  end

  // Selected period in ms
  logic [CNT_W-1:0] wdPeriod;
  always_comb begin
    case (pselEff)
      PSEL_250: wdPeriod = WD_250_MS;             // [R8]
      PSEL_500: wdPeriod = WD_500_MS;             // [R8]
      PSEL_1000: wdPeriod = WD_1000_MS;           // [R8]
      default: wdPeriod = '0;
    endcase
  end
  wire wdEnabled = (pselEff != PSEL_OFF);         // [R9]

  // Power-up hold, longer when the oscillator must start first
  wire [CNT_W-1:0] pwrHold = osc_disable ? CNT_W'(RESET_HOLD_MS + OSC_START_MS)
                                         : RESET_HOLD_MS;  // [R2] [R3]

  // ----------------------------------------------------------------
  // Supervisor sequence
  // ----------------------------------------------------------------
  sup_state_type state_reg;
  sup_state_type state_next;
  logic [CNT_W-1:0] cnt_reg;                      // Millisecond down counter
  logic [CNT_W-1:0] cnt_next;
  logic drive_next;                               // Pull the line low

  wire cntDone = (cnt_reg == '0);

  // Next state and counter; power fail overrides every state
  always_comb begin
    state_next = state_reg;
    cnt_next = (msTick && !cntDone) ? cnt_reg - 1'b1 : cnt_reg;  // [R18]
    if (pfActive) begin
      state_next = ST_PWR_HOLD;                   // [R1]
      cnt_next = pwrHold;                         // Restart hold each fail cycle
    end else begin
      case (state_reg)
        ST_PWR_HOLD: begin
          if (cntDone) begin
            state_next = ST_RUN;
            cnt_next = wdPeriod;                  // Count starts at release [R10]
          end
        end
        ST_RUN: begin
          if (lineFall) begin
            state_next = ST_PB_DEBOUNCE;          // [R5]
            cnt_next = DEBOUNCE_MS;
          end else if (wdEnabled && (strobeFall || wrAccept)) begin
            cnt_next = wdPeriod;                  // Full period reload [R12]
          end else if (wdEnabled && cntDone) begin
            state_next = ST_HOLD;                 // [R13]
            cnt_next = RESET_HOLD_MS;
          end else if (!wdEnabled) begin
            cnt_next = cnt_reg;                   // Disabled: no expiry [R9]
          end
        end
        ST_PB_DEBOUNCE: begin
          if (cntDone) begin
            state_next = ST_PB_WAIT;              // Release drive, sample line [R6]
          end
        end
        ST_PB_WAIT: begin
          if (lineHigh) begin
            state_next = ST_HOLD;                 // Button released [R7]
            cnt_next = RESET_HOLD_MS;
          end
        end
        ST_HOLD: begin
          if (cntDone) begin
            state_next = ST_RUN;
            cnt_next = wdPeriod;                  // [R10]
          end
        end
        default: begin
          state_next = ST_PWR_HOLD;
          cnt_next = pwrHold;
        end
      endcase
    end
  end

  // Drive low in every holding state, never while waiting for release
  assign drive_next = (state_next != ST_RUN) && (state_next != ST_PB_WAIT);

  // State, counter and line drive
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_PWR_HOLD;
      cnt_reg <= RESET_HOLD_MS;
      rstLineOe_n <= 1'b0;                        // Reset asserted from power-up
      resetActive <= 1'b1;
      rstLineOut <= 1'b0;
    end else if (clkEn) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rstLineOe_n <= ~drive_next;                 // [R1] [R5] [R7] [R13]
      resetActive <= drive_next | (state_next == ST_PB_WAIT);
      rstLineOut <= 1'b0;                         // Only ever pulls low [R19]
    end
  end

endmodule

//--- src/supervisor_pkg.sv
// Shared constants and types for the reset supervisor and watchdog.
// Assumes a single 40 MHz system clock drives every consumer.
package supervisor_pkg;

  // ----------------------------------------------------------------
  // Clock and timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40000000;            // System clock rate
  localparam int unsigned TICK_US = 1000;               // Timebase tick, in us
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;  // Cycles per tick

  // ----------------------------------------------------------------
  // Interval lengths, in milliseconds
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 12;                   // Millisecond counter width
  localparam logic [11:0] RESET_HOLD_MS = 12'h0fa;      // Reset active time, 250 ms
  localparam logic [11:0] DEBOUNCE_MS = 12'h0fa;        // Pushbutton debounce, 250 ms
  localparam logic [11:0] WD_250_MS = 12'h0fa;          // Period select 01
  localparam logic [11:0] WD_500_MS = 12'h1f4;          // Period select 10
  localparam logic [11:0] WD_1000_MS = 12'h3e8;         // Period select 11

  // ----------------------------------------------------------------
  // Watchdog register layout
  // ----------------------------------------------------------------
  localparam int unsigned PSEL_LO_BIT = 0;              // Low period-select bit
  localparam int unsigned PSEL_HI_BIT = 1;              // High period-select bit
  localparam logic [1:0] PSEL_OFF = 2'h0;               // Watchdog disabled
  localparam logic [1:0] PSEL_250 = 2'h1;
  localparam logic [1:0] PSEL_500 = 2'h2;
  localparam logic [1:0] PSEL_1000 = 2'h3;
  localparam logic [1:0] PSEL_RESET = 2'h3;             // Power-up selection
  localparam logic [5:0] FIXED_ZERO = 6'h00;            // Bits 7..2

  // Register write port carried as one bundle
  typedef struct packed {
    logic en;          // One-cycle write strobe
    logic [7:0] data;  // Byte to write
  } reg_write_type;

  // Supervisor sequence, Gray-coded along power-up, run, button path
  typedef enum logic [2:0] {
    ST_PWR_HOLD = 3'h0,
    ST_RUN = 3'h1,
    ST_PB_DEBOUNCE = 3'h3,
    ST_PB_WAIT = 3'h2,
    ST_HOLD = 3'h6
  } sup_state_type;

endpackage

//--- testbench/cpu_button_model.sv
// Processor and pushbutton on the far side of the reset line.
// Assumes a pull-up on the line; strobes come from a free counter.
`timescale 1ns/10ps
module cpu_button_model #(
  parameter int GAP = 800  // Strobe falls every GAP+1 cycles
) (
  input wire logic sys_clk,
  input wire logic rstLineOut,
  input wire logic rstLineOe_n,
  input wire logic btnDown,
  input wire logic strobeOn,
  output logic wd_strobe_in,
  output logic rstLineIn
);
  int gapCnt = 0;  // Strobe spacing counter
  initial wd_strobe_in = 1'b1;
  // Pull-up wins unless device or button pulls low
  assign rstLineIn = !((!rstLineOe_n && !rstLineOut) || btnDown);
  // Three-cycle low pulse every GAP+1 cycles; the pin filter drops one-cycle pulses
  always @(posedge sys_clk) begin
    gapCnt <= (gapCnt >= GAP) ? 0 : gapCnt + 1;
    wd_strobe_in <= !(strobeOn && gapCnt >= GAP - 2);
  end
endmodule

//--- testbench/reset_supervisor_watchdog_bench.sv
// Self-checking bench for the reset supervisor and watchdog.
// Assumes a shortened tick of four clocks per millisecond.
`timescale 1ns/10ps
module reset_supervisor_watchdog_bench;
  import supervisor_pkg::*;
  localparam int T = 4;  // Clocks per tick, short for run time
  localparam int OSC = 20;  // Oscillator allowance, ms
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clkEn = 1'b1;
  logic powerFail = 1'b0;
  logic osc_disable = 1'b0;
  logic wrLock = 1'b0;
  logic btnDown = 1'b0;
  logic strobeOn = 1'b0;
  reg_write_type regWr = '0;
  logic wd_strobe_in, rstLineIn, rstLineOut, rstLineOe_n, resetActive;
  logic [7:0] regRdData;
  logic [1:0] psel = PSEL_RESET;  // Expected select
  int err_count = 0;
  int total_checks = 0;
  int seed = 32'he217;
  int wdMs [4] = '{0, 250, 500, 1000};
  always #12.5 sys_clk = ~sys_clk;
  reset_supervisor_watchdog #(.TICK_CYC(T), .OSC_START_MS(12'h014)) DUT (
    .sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .powerFail(powerFail),
    .osc_disable(osc_disable), .wrLock(wrLock), .wd_strobe_in(wd_strobe_in),
    .rstLineIn(rstLineIn), .regWr(regWr), .regRdData(regRdData),
    .rstLineOut(rstLineOut), .rstLineOe_n(rstLineOe_n), .resetActive(resetActive));
  cpu_button_model #(.GAP(200 * T)) partner (
    .sys_clk(sys_clk), .rstLineOut(rstLineOut), .rstLineOe_n(rstLineOe_n),
    .btnDown(btnDown), .strobeOn(strobeOn), .wd_strobe_in(wd_strobe_in),
    .rstLineIn(rstLineIn));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Wait for the drive to reach v, then time it against ms
  task span(input logic v, input int ms);
    int n;
    n = 0;
    while (rstLineOe_n !== v && n < ms * T + 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (rstLineOe_n !== v) begin
      err_count++;
      stop_test;
    end else begin
      check(8'(n >= (ms - 1) * T - 4 && n <= ms * T + 16), 8'h01);
    end
  endtask
  // Line must stay released for cyc clocks
  task stay(input int cyc);
    int n;
    n = 0;
    while (rstLineOe_n === 1'b1 && n < cyc) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(8'(n == cyc), 8'h01);
  endtask
  // One write strobe, readback settles two edges on
  task wr(input logic [7:0] d, input logic lk);
    regWr.data = d;
    regWr.en = 1'b1;
    wrLock = lk;
    @(posedge sys_clk);
    #1;
    regWr.en = 1'b0;
    wrLock = 1'b0;
    if (!lk) psel = d[1:0];
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check(regRdData, {6'h00, PSEL_RESET});
    span(1'b1, 250);
    for (int i = 0; i < 8; i++) begin
      wr(8'($random(seed)), i % 3 == 1);
      check(regRdData, {6'h00, psel});
    end
    clkEn = 1'b0;  // Frozen: this write must be lost
    wr(8'(~psel), 1'b0);
    clkEn = 1'b1;
    psel = ~psel;  // Expected select stays as before
    repeat (2) @(posedge sys_clk);
    #1;
    check(regRdData, {6'h00, psel});
    $display("Power-up and register tests done");
    for (int p = 1; p < 4; p++) begin
      wr(8'(p), 1'b0);
      span(1'b0, wdMs[p]);
      span(1'b1, 250);
    end
    span(1'b0, 1000);
    span(1'b1, 250);
    $display("Watchdog period tests done");
    wr(8'(PSEL_250), 1'b0);
    strobeOn = 1'b1;
    stay(1500 * T);
    for (int k = 0; k < 900 && wd_strobe_in !== 1'b0; k++) begin
      @(posedge sys_clk);
      #1;
    end
    if (wd_strobe_in !== 1'b0) begin
      err_count++;
      stop_test;
    end
    repeat (4) @(posedge sys_clk);  // Let the whole pulse through the filter
    #1;
    strobeOn = 1'b0;
    span(1'b0, 250);
    span(1'b1, 250);
    wr(8'(PSEL_OFF), 1'b0);
    stay(1100 * T);
    $display("Strobe and disable tests done");
    btnDown = 1'b1;
    span(1'b0, 0);
    span(1'b1, 250);
    repeat (400) @(posedge sys_clk);
    #1;
    check(8'(resetActive), 8'h01);
    btnDown = 1'b0;
    span(1'b0, 0);
    span(1'b1, 250);
    $display("Pushbutton test done");
    osc_disable = 1'b1;
    powerFail = 1'b1;
    span(1'b0, 0);
    repeat (200) @(posedge sys_clk);
    #1;
    check(8'(rstLineOe_n), 8'h00);
    powerFail = 1'b0;
    span(1'b1, 250 + OSC);
    $display("Power fail test done");
    arst_n = 1'b0;  // Mid-run reset returns to the power-up state
    osc_disable = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check(regRdData, {6'h00, PSEL_RESET});
    span(1'b1, 250);
    $display("Mid-run reset test done");
    stop_test;
  end
endmodule

//--- testbench/supervisor_asserts.sv
// Port checker for the reset supervisor and watchdog.
// Assumes it is bound onto reset_supervisor_watchdog.
`timescale 1ns/10ps
module supervisor_asserts #(
  parameter int unsigned TICK_CYC = 4  // Cycles per ms tick
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic powerFail,
  input wire logic wrLock,
  input wire logic rstLineIn,
  input wire supervisor_pkg::reg_write_type regWr,
  input wire logic [7:0] regRdData,
  input wire logic rstLineOut,
  input wire logic rstLineOe_n,
  input wire logic resetActive
);
  import supervisor_pkg::*;
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  localparam int unsigned MIN_LOW = 249 * TICK_CYC;  // Shortest legal pull, one tick short
  int unsigned lowCnt;  // Cycles the line has been pulled low
  wire [9:0] outWord = {regRdData, rstLineOe_n, resetActive};  // Registered outputs
  // Count each low stretch; a freeze only lengthens it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) lowCnt <= 32'h0;
    else lowCnt <= rstLineOe_n ? 32'h0 : lowCnt + 32'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence failing; powerFail [*6]; endsequence
  sequence wrTaken; clkEn && regWr.en && !wrLock ##1 clkEn; endsequence
  sequence wrLocked; clkEn && regWr.en && wrLock ##1 clkEn; endsequence
  sequence quietOff; (regRdData[1:0] == PSEL_OFF && !powerFail && rstLineIn) [*5]; endsequence
  sequence pressed; $fell(rstLineIn) && !resetActive; endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_DRIVE_LOW_ONLY: assert property (rstLineOut == 1'b0)
    else $error("reset line driven high");
  AST_FIXED_ZERO: assert property (regRdData[7:2] == FIXED_ZERO)
    else $error("fixed bits read nonzero");
  AST_IDLE_RELEASED: assert property (!resetActive |-> rstLineOe_n)
    else $error("line pulled while idle");
  AST_POWER_FAIL: assert property (failing |-> ##[0:2] !rstLineOe_n)
    else $error("power fail not driving reset");
  AST_WRITE_TAKEN: assert property (wrTaken |-> ##1 regRdData[1:0] == $past(regWr.data[1:0], 2))
    else $error("written select not read back");
  AST_WRITE_LOCKED: assert property (wrLocked |-> ##1 $stable(regRdData))
    else $error("locked write changed register");
  AST_MIN_HOLD: assert property ($rose(rstLineOe_n) |-> lowCnt >= MIN_LOW)
    else $error("reset pull too short");
  AST_WD_DISABLED: assert property (quietOff ##0 !resetActive |=> !resetActive)
    else $error("disabled watchdog fired");
  AST_FREEZE: assert property (!clkEn |=> $stable(outWord))
    else $error("outputs moved while frozen");
  AST_BUTTON_PULL: assert property (pressed |-> ##[1:6] !rstLineOe_n)
    else $error("button edge not answered by pull");
endmodule
bind reset_supervisor_watchdog supervisor_asserts #(.TICK_CYC(TICK_CYC)) checker_inst (
  .sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .powerFail(powerFail),
  .wrLock(wrLock), .rstLineIn(rstLineIn), .regWr(regWr), .regRdData(regRdData),
  .rstLineOut(rstLineOut), .rstLineOe_n(rstLineOe_n), .resetActive(resetActive));
